// ### spq_params.svh
`ifndef SPQ_PARAMS_SVH
`define SPQ_PARAMS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define SPQ_A_GLOB 8'h00
`define SPQ_A_TMAP 8'h04
`define SPQ_A_CPT_LO 8'h08
`define SPQ_A_CPT_HI 8'h14
`define SPQ_A_WGT 8'h18
`define SPQ_A_STAT 8'h1c
`define SPQ_A_PCTL 8'h20
`define SPQ_A_PAUX 8'h40
`define SPQ_A_PMASK 8'he0
`define SPQ_NPORT 3'd5
// ----------------------------------------
// field positions
// ----------------------------------------
`define SPQ_G_TAIL 1
`define SPQ_G_STRICT 3
`define SPQ_G_FL_DYN 4
`define SPQ_G_FL_STA 5
`define SPQ_G_MAP 6
`define SPQ_G_SNI 8
`define SPQ_P_RMV 1
`define SPQ_P_INS 2
`define SPQ_P_PPRI 3
`define SPQ_P_TPRI 5
`define SPQ_P_CPEN 6
`define SPQ_P_CEIL 7
`define SPQ_P_QSEL 8
`define SPQ_P_TXEN 10
`define SPQ_P_RXEN 11
`define SPQ_P_LDIS 12
`define SPQ_P_PVID 16
// ----------------------------------------
// codes and reset values
// ----------------------------------------
`define SPQ_Q1 2'b00
`define SPQ_Q2 2'b01
`define SPQ_Q4 2'b10
`define SPQ_RST_GLOB 32'h0000_0000
`define SPQ_RST_TMAP 32'h0000_fa50
`define SPQ_RST_WGT 32'h0102_0408
`define SPQ_RST_PCTL 32'h0000_0c00
`define SPQ_RST_PAUX 32'h0000_001f
`define SPQ_TPID 16'h8100
`define SPQ_TAG_POS 5'd12
`define SPQ_TAG_END 5'd16
`define SPQ_CRC_POLY 32'hedb8_8320
`define SPQ_CRC_INIT 32'hffff_ffff
`endif

// ### spq_pkg.sv
package spq_pkg;
  typedef enum logic [1:0] {ST_DATA, ST_INS, ST_TAIL, ST_FCS} spq_eg_e;
  typedef logic [31:0] spq_word_t;
  typedef logic [6:0] spq_credit_t;
endpackage

// ### spq_port_policy.sv
// Summary of operation
// - queue select 00 one queue, 01 two queues, 10 four queues per egress port
// - split queues: top queue (3 with four queues, 1 with two) served highest, queue 0 lowest
// - unsplit port puts every frame in its single queue alike
// - four queues: strict order or weighted fair, 7-bit weights reset 8,4,2,1
// - two queues: global bits 7:6 map 2-bit level to high or low
// - port priority field bits 4:3 gives the level 0-3 when no tag or type-of-service rule applies
// - tagged frames: 3-bit user priority mapped through table to 2-bit level
// - tag priority used only when port control bit 5 is set
// - insert bit 2: untagged frames from allowed sources get ingress default tag
// - inserted tag is 2-byte protocol id then 2-byte control info
// - remove bit 1: tagged frames lose their tag, untagged pass unchanged
// - check sequence recomputed whenever a tag is added or removed
// - ceiling bit 7: priority above port default is replaced by default
// - upper six type-of-service bits index 64 two-bit entries of 128-bit table
// - ports 1-4 states set by transmit, receive and learning-disable bits
// - blocked port still sends override-matched frames to the host port
// - global bits 5 and 4 flush table entries of learning-disabled ports
// - tail tag only on host port when global bit 1; bits 3:0 select
// - serial interface moves one bit per clock with valid and collision
// - tail tag to host: bits 1:0 give ingress port 1 to 4
// - host tail tag bits 3:0 one-hot port mask, all ones all, zero reserved
//
// The Wishbone slave port and the register addresses are this design's own decisions.
`include "spq_params.svh"
module spq_port_policy (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cls_valid,
  input wire logic [2:0] cls_port,
  input wire logic [2:0] cls_eg_port,
  input wire logic cls_tagged,
  input wire logic [2:0] cls_user_prio,
  input wire logic cls_is_ip,
  input wire logic [7:0] cls_tos,
  input wire logic [7:0] cls_tail_tag,
  input wire logic [4:0] cls_lookup_mask,
  input wire logic cls_override_hit,
  output logic res_valid,
  output logic [1:0] res_level,
  output logic [1:0] res_queue,
  output logic [2:0] res_user_prio,
  output logic [4:0] res_fwd_mask,
  output logic res_learn,
  input wire logic sch_req,
  input wire logic [2:0] sch_port,
  input wire logic [3:0] sch_pending,
  output logic sch_grant_valid,
  output logic [1:0] sch_grant,
  output logic flush_pulse,
  output logic flush_dyn,
  output logic flush_sta,
  output logic [3:0] flush_port_mask,
  input wire logic [2:0] eg_port,
  input wire logic [2:0] eg_src_port,
  input wire logic eg_tagged,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic in_last,
  output logic in_ready,
  output logic out_valid,
  output logic [7:0] out_data,
  output logic out_last,
  input wire logic out_ready,
  output logic sni_txen,
  output logic sni_txd,
  input wire logic sni_col
);
  import spq_pkg::*;

  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [1:0] hi_q(input logic [3:0] m);
    return m[3] ? 2'd3 : m[2] ? 2'd2 : m[1] ? 2'd1 : 2'd0;
  endfunction

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] x;
    x = c ^ {24'h0, d};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ `SPQ_CRC_POLY) : (x >> 1);
    end
    return x;
  endfunction

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  spq_word_t glob_r, tmap_r, wgt_r;
  spq_word_t cpt_r [4];
  spq_word_t pctl_r [5];
  spq_word_t paux_r [5];
  logic ack_r, col_r;
  logic [31:0] rdat_r;
  logic [1:0] last_lv_r;
  logic [3:0] ldis_v;
  logic eg_busy;

  wire wb_req = wb_cyc_i && wb_stb_i && !ack_r;
  wire wb_wr = wb_req && wb_we_i;
  wire [2:0] adr_pi = wb_adr_i[4:2];
  wire [1:0] adr_ci = 2'(wb_adr_i[4:2] - 3'd2);
  wire adr_al = wb_adr_i[1:0] == 2'b00;
  wire hit_glob = wb_adr_i == `SPQ_A_GLOB;
  wire hit_tmap = wb_adr_i == `SPQ_A_TMAP;
  wire hit_cpt = adr_al && wb_adr_i >= `SPQ_A_CPT_LO && wb_adr_i <= `SPQ_A_CPT_HI;
  wire hit_wgt = wb_adr_i == `SPQ_A_WGT;
  wire hit_stat = wb_adr_i == `SPQ_A_STAT;
  wire hit_pctl = adr_al && (wb_adr_i & `SPQ_A_PMASK) == `SPQ_A_PCTL && adr_pi < `SPQ_NPORT;
  wire hit_paux = adr_al && (wb_adr_i & `SPQ_A_PMASK) == `SPQ_A_PAUX && adr_pi < `SPQ_NPORT;
  wire [31:0] stat_v = {28'h0, last_lv_r, eg_busy, col_r};
  wire [31:0] rd_mux = hit_glob ? glob_r : hit_tmap ? tmap_r : hit_cpt ? cpt_r[adr_ci] :
                       hit_wgt ? wgt_r : hit_stat ? stat_v : hit_pctl ? pctl_r[adr_pi] :
                       hit_paux ? paux_r[adr_pi] : 32'h0;
  wire fl_wr = wb_wr && hit_glob && wb_sel_i[0] &&
               (wb_dat_i[`SPQ_G_FL_DYN] || wb_dat_i[`SPQ_G_FL_STA]);

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
      rdat_r <= 32'h0;
    end else begin
      ack_r <= wb_req;
      rdat_r <= (wb_req && !wb_we_i) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      glob_r <= `SPQ_RST_GLOB;
      tmap_r <= `SPQ_RST_TMAP;
      wgt_r <= `SPQ_RST_WGT;
      for (int i = 0; i < 4; i++) cpt_r[i] <= 32'h0;
      for (int i = 0; i < 5; i++) begin
        pctl_r[i] <= `SPQ_RST_PCTL;
        paux_r[i] <= `SPQ_RST_PAUX;
      end
    end else if (wb_wr) begin
      // flush bits act once and are not kept
      if (hit_glob) glob_r <= wmerge(glob_r, wb_dat_i, wb_sel_i) & 32'hffff_ffcf;
      if (hit_tmap) tmap_r <= wmerge(tmap_r, wb_dat_i, wb_sel_i);
      if (hit_cpt) cpt_r[adr_ci] <= wmerge(cpt_r[adr_ci], wb_dat_i, wb_sel_i);
      if (hit_wgt) wgt_r <= wmerge(wgt_r, wb_dat_i, wb_sel_i) & 32'h7f7f_7f7f;
      if (hit_pctl) pctl_r[adr_pi] <= wmerge(pctl_r[adr_pi], wb_dat_i, wb_sel_i);
      if (hit_paux) paux_r[adr_pi] <= wmerge(paux_r[adr_pi], wb_dat_i, wb_sel_i) & 32'h1f;
    end
  end

  // ----------------------------------------
  // table flush
  // ----------------------------------------
  assign ldis_v = {pctl_r[3][`SPQ_P_LDIS], pctl_r[2][`SPQ_P_LDIS],
                   pctl_r[1][`SPQ_P_LDIS], pctl_r[0][`SPQ_P_LDIS]};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flush_pulse <= 1'b0;
      flush_dyn <= 1'b0;
      flush_sta <= 1'b0;
      flush_port_mask <= 4'h0;
    end else begin
      flush_pulse <= fl_wr;
      flush_dyn <= fl_wr && wb_dat_i[`SPQ_G_FL_DYN];
      flush_sta <= fl_wr && wb_dat_i[`SPQ_G_FL_STA];
      flush_port_mask <= fl_wr ? ldis_v : 4'h0;
    end
  end

  a_flush_port_mask: assert property (@(posedge clk) disable iff (rst)
    flush_pulse |-> flush_port_mask == $past(ldis_v))
    else $error("flush mask differs from learning-disabled ports");

  // ----------------------------------------
  // ingress classification
  // ----------------------------------------
  wire [31:0] pc_in = pctl_r[cls_port];
  wire [2:0] dflt_up = pc_in[`SPQ_P_PVID + 13 +: 3];
  wire [127:0] cpt_bits = {cpt_r[3], cpt_r[2], cpt_r[1], cpt_r[0]};
  wire [2:0] up_ceil = (pc_in[`SPQ_P_CEIL] && cls_tagged && cls_user_prio > dflt_up) ?
                       dflt_up : cls_user_prio;
  wire [1:0] lv_tag = tmap_r[{up_ceil, 1'b0} +: 2];
  wire [1:0] lv_cp = cpt_bits[{cls_tos[7:2], 1'b0} +: 2];
  wire [1:0] lv = (pc_in[`SPQ_P_TPRI] && cls_tagged) ? lv_tag :
                  (pc_in[`SPQ_P_CPEN] && cls_is_ip) ? lv_cp :
                  pc_in[`SPQ_P_PPRI +: 2];
  wire [1:0] cq_mode = pctl_r[cls_eg_port][`SPQ_P_QSEL +: 2];
  wire q2_hi = lv > glob_r[`SPQ_G_MAP +: 2];
  wire [1:0] cq = (cq_mode == `SPQ_Q4) ? lv :
                  (cq_mode == `SPQ_Q2) ? {1'b0, q2_hi} : 2'd0;
  wire [4:0] txok = {1'b1, pctl_r[3][`SPQ_P_TXEN], pctl_r[2][`SPQ_P_TXEN],
                     pctl_r[1][`SPQ_P_TXEN], pctl_r[0][`SPQ_P_TXEN]};
  wire from_host_tt = cls_port == 3'd4 && glob_r[`SPQ_G_TAIL];
  wire [4:0] fwd = from_host_tt ? {1'b0, cls_tail_tag[3:0]} :
                   pc_in[`SPQ_P_RXEN] ? (cls_lookup_mask & txok) :
                   cls_override_hit ? 5'h10 : 5'h00;
  logic [1:0] res_qmode_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      res_valid <= 1'b0;
      res_level <= 2'd0;
      res_queue <= 2'd0;
      res_user_prio <= 3'd0;
      res_fwd_mask <= 5'h0;
      res_learn <= 1'b0;
      res_qmode_r <= 2'd0;
      last_lv_r <= 2'd0;
    end else begin
      res_valid <= cls_valid;
      if (cls_valid) begin
        res_level <= lv;
        res_queue <= cq;
        res_user_prio <= up_ceil;
        res_fwd_mask <= fwd;
        res_learn <= !pc_in[`SPQ_P_LDIS];
        res_qmode_r <= cq_mode;
        last_lv_r <= lv;
      end
    end
  end

  a_single_queue: assert property (@(posedge clk) disable iff (rst)
    res_valid && res_qmode_r == `SPQ_Q1 |-> res_queue == 2'd0)
    else $error("unsplit port used a queue other than 0");

  a_blocked_override: assert property (@(posedge clk) disable iff (rst)
    cls_valid && cls_port < 3'd4 && !pc_in[`SPQ_P_RXEN] && cls_override_hit
    |=> res_fwd_mask == 5'h10)
    else $error("override frame of blocked port not sent to host");

  a_learn_state: assert property (@(posedge clk) disable iff (rst)
    cls_valid |=> res_learn == !$past(pc_in[`SPQ_P_LDIS]))
    else $error("learn flag does not follow learning disable");

  // ----------------------------------------
  // egress scheduler
  // ----------------------------------------
  spq_credit_t cr_r [5][4];
  wire [1:0] smode = pctl_r[sch_port][`SPQ_P_QSEL +: 2];
  logic [3:0] crd_ok;
  always_comb begin
    for (int q = 0; q < 4; q++) crd_ok[q] = sch_pending[q] && cr_r[sch_port][q] != 7'd0;
  end
  wire wfq_any = |crd_ok;
  wire strict = glob_r[`SPQ_G_STRICT];
  wire [1:0] wfq_q = wfq_any ? hi_q(crd_ok) : hi_q(sch_pending);
  wire [1:0] g_q = (smode == `SPQ_Q4) ? (strict ? hi_q(sch_pending) : wfq_q) :
                   (smode == `SPQ_Q2) ? {1'b0, sch_pending[1]} : 2'd0;
  wire g_ok = (smode == `SPQ_Q4) ? |sch_pending :
              (smode == `SPQ_Q2) ? |sch_pending[1:0] : sch_pending[0];
  wire wfq_step = sch_req && g_ok && smode == `SPQ_Q4 && !strict;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sch_grant_valid <= 1'b0;
      sch_grant <= 2'd0;
      for (int p = 0; p < 5; p++) begin
        for (int q = 0; q < 4; q++) cr_r[p][q] <= 7'd0;
      end
    end else begin
      sch_grant_valid <= sch_req && g_ok;
      if (sch_req && g_ok) sch_grant <= g_q;
      if (wfq_step) begin
        for (int q = 0; q < 4; q++) begin
          if (!wfq_any) begin
            cr_r[sch_port][q] <= wgt_r[8*q +: 7] - ((2'(q) == wfq_q) ? 7'd1 : 7'd0);
          end else if (2'(q) == wfq_q) begin
            cr_r[sch_port][q] <= cr_r[sch_port][q] - 7'd1;
          end
        end
      end
    end
  end

  a_strict_top: assert property (@(posedge clk) disable iff (rst)
    sch_req && smode == `SPQ_Q4 && strict && sch_pending[3] |=> sch_grant == 2'd3)
    else $error("strict scheduler did not pick queue 3");

  // ----------------------------------------
  // egress frame editor
  // ----------------------------------------
  spq_eg_e st_r;
  logic [4:0] cnt_r;
  logic [1:0] idx_r;
  logic idone_r;
  logic [31:0] crc_r;
  logic ov_r, ol_r;
  logic [7:0] od_r;
  logic [7:0] sh_r;
  logic [3:0] sn_r;
  logic [7:0] eb;

  wire sni_en = glob_r[`SPQ_G_SNI];
  wire ordy = sni_en ? (sn_r <= 4'd1) : out_ready;
  wire load = !ov_r || ordy;
  wire [31:0] pe = pctl_r[eg_port];
  wire [31:0] ps = pctl_r[eg_src_port];
  wire ins_c = pe[`SPQ_P_INS] && paux_r[eg_port][eg_src_port] && !eg_tagged;
  wire rmv_c = pe[`SPQ_P_RMV] && eg_tagged;
  wire tail_c = glob_r[`SPQ_G_TAIL] && eg_port == 3'd4;
  wire ins_hit = st_r == ST_DATA && !idone_r && cnt_r == `SPQ_TAG_POS && ins_c && in_valid;
  wire rmv_hit = st_r == ST_DATA && rmv_c && cnt_r >= `SPQ_TAG_POS && cnt_r < `SPQ_TAG_END;
  wire take = in_valid && in_ready;
  wire emit = load && (st_r == ST_DATA ? (take && !rmv_hit) : 1'b1);
  wire [15:0] tpid = `SPQ_TPID;
  wire [7:0] tag_b = (idx_r == 2'd0) ? tpid[15:8] : (idx_r == 2'd1) ? tpid[7:0] :
                     (idx_r == 2'd2) ? ps[31:24] : ps[23:16];
  wire [7:0] tail_b = {6'h0, eg_src_port[1:0]};
  wire [7:0] fcs_b = ~crc_r[{idx_r, 3'b000} +: 8];

  assign in_ready = load && st_r == ST_DATA && !ins_hit;
  assign eg_busy = st_r != ST_DATA || cnt_r != 5'd0;
  assign out_valid = ov_r;
  assign out_data = od_r;
  assign out_last = ol_r;

  always_comb begin
    unique case (st_r)
      ST_DATA: eb = in_data;
      ST_INS: eb = tag_b;
      ST_TAIL: eb = tail_b;
      ST_FCS: eb = fcs_b;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ov_r <= 1'b0;
      od_r <= 8'h0;
      ol_r <= 1'b0;
    end else if (load) begin
      ov_r <= emit;
      od_r <= emit ? eb : od_r;
      ol_r <= st_r == ST_FCS && idx_r == 2'd3;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      crc_r <= `SPQ_CRC_INIT;
    end else if (emit && st_r == ST_FCS && idx_r == 2'd3) begin
      crc_r <= `SPQ_CRC_INIT;
    end else if (emit && st_r != ST_FCS) begin
      crc_r <= crc_byte(crc_r, eb);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= ST_DATA;
      cnt_r <= 5'd0;
      idx_r <= 2'd0;
      idone_r <= 1'b0;
    end else if (load) begin
      unique case (st_r)
        ST_DATA: begin
          if (ins_hit) begin
            st_r <= ST_INS;
            idx_r <= 2'd0;
          end else if (take) begin
            cnt_r <= (cnt_r == `SPQ_TAG_END) ? cnt_r : cnt_r + 5'd1;
            idx_r <= 2'd0;
            if (in_last) st_r <= tail_c ? ST_TAIL : ST_FCS;
          end
        end
        ST_INS: begin
          idx_r <= idx_r + 2'd1;
          if (idx_r == 2'd3) begin
            st_r <= ST_DATA;
            idone_r <= 1'b1;
          end
        end
        ST_TAIL: st_r <= ST_FCS;
        ST_FCS: begin
          idx_r <= idx_r + 2'd1;
          if (idx_r == 2'd3) begin
            st_r <= ST_DATA;
            cnt_r <= 5'd0;
            idone_r <= 1'b0;
          end
        end
      endcase
    end
  end

  a_ins_tpid: assert property (@(posedge clk) disable iff (rst)
    st_r == ST_INS && idx_r == 2'd0 && load |=> out_valid && out_data == 8'h81)
    else $error("inserted tag does not open with protocol id");

  a_rmv_silent: assert property (@(posedge clk) disable iff (rst)
    rmv_hit && take |=> !out_valid)
    else $error("byte of removed tag was emitted");

  a_tail_src: assert property (@(posedge clk) disable iff (rst)
    st_r == ST_TAIL && load |=> out_data == {6'h0, $past(eg_src_port[1:0])})
    else $error("tail byte does not name ingress port");

  a_fcs_end: assert property (@(posedge clk) disable iff (rst)
    st_r == ST_FCS && idx_r == 2'd3 && load |=> out_last && out_valid)
    else $error("frame did not end on fourth check byte");

  // ----------------------------------------
  // legacy serial transmit
  // ----------------------------------------
  wire sni_take = sni_en && ov_r && sn_r <= 4'd1;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sh_r <= 8'h0;
      sn_r <= 4'd0;
      sni_txen <= 1'b0;
      sni_txd <= 1'b0;
    end else begin
      sni_txen <= sn_r != 4'd0;
      sni_txd <= (sn_r != 4'd0) ? sh_r[0] : 1'b0;
      if (sni_take) begin
        sh_r <= od_r;
        sn_r <= 4'd8;
      end else if (sn_r != 4'd0) begin
        sh_r <= sh_r >> 1;
        sn_r <= sn_r - 4'd1;
      end
    end
  end

  // collision seen sticky; a new hit beats the software clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      col_r <= 1'b0;
    end else if (sni_col && sni_txen) begin
      col_r <= 1'b1;
    end else if (wb_wr && hit_stat && wb_sel_i[0] && wb_dat_i[0]) begin
      col_r <= 1'b0;
    end
  end

  a_sni_bitrate: assert property (@(posedge clk) disable iff (rst)
    sni_take |=> ##1 sni_txen && sni_txd == $past(od_r[0], 2))
    else $error("serial bit does not follow loaded byte");

endmodule

// ### spq_host_model.sv
// ----------------------------------------
// host processor receiving the egress stream
// ----------------------------------------
module spq_host_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic clr,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_last,
  output logic out_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] got [0:63];
  int n;
  logic last_seen;
  // receive only: never sends toward a blocked port, keeps every byte it is given
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_ready <= 1'b0;
      n <= 0;
      last_seen <= 1'b0;
    end else begin
      out_ready <= slow ? !out_ready : 1'b1;
      if (clr) begin
        n <= 0;
        last_seen <= 1'b0;
      end else if (out_valid && out_ready) begin
        got[n] <= out_data;
        n <= n + 1;
        last_seen <= out_last;
      end
    end
  end
endmodule

// ### test_switch_port_qos_stp_tailtag.sv
`include "spq_params.svh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module test_switch_port_qos_stp_tailtag;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cls_valid, cls_tagged, cls_is_ip;
  logic cls_override_hit, res_valid, res_learn, sch_req, sch_grant_valid, flush_pulse;
  logic flush_dyn, flush_sta, eg_tagged, in_valid, in_last, in_ready, out_valid, out_last;
  logic out_ready, sni_txen, sni_txd, sni_col, slow, clr;
  logic [7:0] wb_adr_i, cls_tos, cls_tail_tag, in_data, out_data;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [3:0] wb_sel_i, sch_pending, flush_port_mask;
  logic [2:0] cls_port, cls_eg_port, cls_user_prio, res_user_prio, sch_port, eg_port;
  logic [2:0] eg_src_port;
  logic [1:0] res_level, res_queue, sch_grant;
  logic [4:0] cls_lookup_mask, res_fwd_mask;
  logic [6:0] fl;
  logic [7:0] tx[$], ex[$];
  int n_fail, checks, cyc_n;
  spq_port_policy u_dut (.*);
  spq_host_model u_host (.clk, .rst, .slow, .clr, .out_valid, .out_data, .out_last, .out_ready);
  // ----------------------------------------
  // clock, timeout and verdict
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // bus, classify, schedule and frame helpers
  // ----------------------------------------
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk);
    while (wb_ack_o !== 1'b1) @(posedge clk);
    rd = wb_dat_o;
    fl = {flush_pulse, flush_dyn, flush_sta, flush_port_mask};
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic cl(input logic [2:0] p, input logic tg, input logic [2:0] up,
                    input logic [7:0] tos, input logic [7:0] tt, input logic ov);
    cls_valid <= 1'b1;
    cls_port <= p;
    cls_tagged <= tg;
    cls_user_prio <= up;
    cls_is_ip <= (tos != 8'h00);
    cls_tos <= tos;
    cls_tail_tag <= tt;
    cls_override_hit <= ov;
    @(posedge clk);
    cls_valid <= 1'b0;
    @(negedge clk);
    `CHK(res_valid, 1'b1)
    @(posedge clk);
  endtask
  task automatic sc(input logic [3:0] pend, input logic [1:0] g);
    sch_req <= 1'b1;
    sch_pending <= pend;
    @(posedge clk);
    sch_req <= 1'b0;
    @(negedge clk);
    `CHK(sch_grant_valid, 1'b1)
    `CHK(sch_grant, g)
    @(posedge clk);
  endtask
  function automatic logic [31:0] crc(input logic [7:0] q[$]);
    logic [31:0] c;
    c = `SPQ_CRC_INIT;
    foreach (q[i]) begin
      c = c ^ {24'h0, q[i]};
      repeat (8) c = c[0] ? ((c >> 1) ^ `SPQ_CRC_POLY) : (c >> 1);
    end
    return ~c;
  endfunction
  task automatic fr();
    logic [31:0] f;
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    foreach (tx[i]) begin
      in_valid <= 1'b1;
      in_data <= tx[i];
      in_last <= (i == tx.size() - 1);
      @(negedge clk);
      while (in_ready !== 1'b1) @(negedge clk);
      @(posedge clk);
    end
    in_valid <= 1'b0;
    in_last <= 1'b0;
    f = crc(ex);
    for (int k = 0; k < 4; k++) ex.push_back(f[8*k+:8]);
    while (u_host.last_seen !== 1'b1) @(posedge clk);
    @(posedge clk);
    `CHK(u_host.n, ex.size())
    foreach (ex[i]) `CHK(u_host.got[i], ex[i])
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    `CHK(in_ready, 1'b1)
    rdchk(`SPQ_A_PCTL, `SPQ_RST_PCTL);
    rdchk(`SPQ_A_WGT, 32'h0102_0408);
    rdchk(`SPQ_A_TMAP, `SPQ_RST_TMAP);
    rdchk(`SPQ_A_PAUX, 32'h0000_001f);
    rdchk(`SPQ_A_GLOB, 32'h0000_0000);
    rdchk(8'hfc, 32'h0000_0000);
    wb(1'b1, `SPQ_A_WGT, 32'hffff_ffff);
    rdchk(`SPQ_A_WGT, 32'h7f7f_7f7f);
    $display("registers done");
  endtask
  task automatic t_class();
    wb(1'b1, 8'h20, 32'h0000_0c08);
    cl(3'd0, 1'b1, 3'd5, 8'h00, 8'h00, 1'b0);
    `CHK(res_level, 2'd1)
    wb(1'b1, 8'h20, 32'h0000_0c28);
    cl(3'd0, 1'b1, 3'd5, 8'h00, 8'h00, 1'b0);
    `CHK(res_level, 2'd2)
    wb(1'b1, 8'h20, 32'h4000_0ca8);
    cl(3'd0, 1'b1, 3'd6, 8'h00, 8'h00, 1'b0);
    `CHK(res_user_prio, 3'd2)
    cl(3'd0, 1'b1, 3'd1, 8'h00, 8'h00, 1'b0);
    `CHK(res_user_prio, 3'd1)
    wb(1'b1, `SPQ_A_CPT_HI, 32'hc000_0000);
    wb(1'b1, 8'h20, 32'h0000_0c48);
    cl(3'd0, 1'b0, 3'd0, 8'hfc, 8'h00, 1'b0);
    `CHK(res_level, 2'd3)
    `CHK(res_queue, 2'd0)
    cl(3'd0, 1'b0, 3'd0, 8'hf8, 8'h00, 1'b0);
    `CHK(res_level, 2'd0)
    wb(1'b1, 8'h20, 32'h0000_0e48);
    cl(3'd0, 1'b0, 3'd0, 8'hfc, 8'h00, 1'b0);
    `CHK(res_queue, 2'd3)
    wb(1'b1, 8'h20, 32'h0000_0d48);
    cl(3'd0, 1'b0, 3'd0, 8'hfc, 8'h00, 1'b0);
    `CHK(res_queue, 2'd1)
    wb(1'b1, `SPQ_A_GLOB, 32'h0000_00c0);
    cl(3'd0, 1'b0, 3'd0, 8'hfc, 8'h00, 1'b0);
    `CHK(res_queue, 2'd0)
    $display("classification done");
  endtask
  task automatic t_stp();
    wb(1'b1, 8'h24, 32'h0000_1000);
    cl(3'd1, 1'b0, 3'd0, 8'h00, 8'h00, 1'b1);
    `CHK({res_fwd_mask, res_learn}, 6'b10000_0)
    cl(3'd1, 1'b0, 3'd0, 8'h00, 8'h00, 1'b0);
    `CHK(res_fwd_mask, 5'h00)
    wb(1'b1, `SPQ_A_GLOB, 32'h0000_0030);
    `CHK(fl, 7'b111_0010)
    wb(1'b1, 8'h24, 32'h0000_0c00);
    cl(3'd1, 1'b0, 3'd0, 8'h00, 8'h00, 1'b0);
    `CHK({res_fwd_mask, res_learn}, 6'b00110_1)
    wb(1'b1, `SPQ_A_GLOB, 32'h0000_0002);
    cl(3'd4, 1'b0, 3'd0, 8'h00, 8'h0f, 1'b0);
    `CHK(res_fwd_mask, 5'h0f)
    cl(3'd4, 1'b0, 3'd0, 8'h00, 8'hf8, 1'b0);
    `CHK(res_fwd_mask, 5'h08)
    cl(3'd4, 1'b0, 3'd0, 8'h00, 8'h00, 1'b0);
    `CHK(res_fwd_mask, 5'h00)
    $display("spanning tree and tail mask done");
  endtask
  task automatic t_sched();
    wb(1'b1, `SPQ_A_GLOB, 32'h0000_0008);
    wb(1'b1, 8'h20, 32'h0000_0e00);
    sc(4'hf, 2'd3);
    sc(4'h5, 2'd2);
    wb(1'b1, `SPQ_A_GLOB, 32'h0000_0000);
    wb(1'b1, `SPQ_A_WGT, 32'h0101_0101);
    sc(4'hf, 2'd3);
    sc(4'hf, 2'd2);
    wb(1'b1, 8'h20, 32'h0000_0d00);
    sc(4'h3, 2'd1);
    wb(1'b1, 8'h20, 32'h0000_0c00);
    sc(4'h1, 2'd0);
    $display("scheduler done");
  endtask
  task automatic t_frames();
    wb(1'b1, `SPQ_A_GLOB, 32'h0000_0002);
    wb(1'b1, 8'h20, 32'h0000_0c04);
    wb(1'b1, 8'h24, 32'ha005_0c00);
    slow <= 1'b1;
    eg_port <= 3'd0;
    eg_src_port <= 3'd1;
    tx = {};
    for (int i = 0; i < 14; i++) tx.push_back(i[7:0]);
    ex = {tx[0:11], 8'h81, 8'h00, 8'ha0, 8'h05, tx[12:13]};
    fr();
    wb(1'b1, 8'h20, 32'h0000_0c02);
    eg_tagged <= 1'b1;
    tx = ex[0:17];
    ex = {tx[0:11], tx[16:17]};
    fr();
    wb(1'b1, 8'h20, 32'h0000_0c00);
    eg_tagged <= 1'b0;
    tx = {8'h55, 8'haa};
    ex = tx;
    fr();
    eg_port <= 3'd4;
    ex = {tx[0:1], 8'h01};
    fr();
    $display("egress frames done");
  endtask
  task automatic t_sni();
    wb(1'b1, `SPQ_A_GLOB, 32'h0000_0100);
    in_valid <= 1'b1;
    in_data <= 8'ha5;
    in_last <= 1'b1;
    @(posedge clk);
    while (in_ready !== 1'b1) @(posedge clk);
    in_valid <= 1'b0;
    in_last <= 1'b0;
    while (sni_txen !== 1'b1) @(posedge clk);
    sni_col <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      `CHK(sni_txd, in_data[i])
      @(posedge clk);
      sni_col <= 1'b0;
    end
    while (sni_txen === 1'b1) @(posedge clk);
    rdchk(`SPQ_A_STAT, 32'h0000_0001);
    wb(1'b1, `SPQ_A_STAT, 32'h0000_0001);
    rdchk(`SPQ_A_STAT, 32'h0000_0000);
    $display("serial done");
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, cls_valid, cls_tagged, cls_is_ip, cls_override_hit} = '0;
    {sch_req, eg_tagged, in_valid, in_last, sni_col, slow, clr} = '0;
    {wb_adr_i, wb_dat_i, cls_tos, cls_tail_tag, in_data, sch_pending} = '0;
    {cls_port, cls_eg_port, cls_user_prio, sch_port, eg_port, eg_src_port} = '0;
    wb_sel_i = 4'hf;
    cls_lookup_mask = 5'h06;
    rst = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_class();
    t_stp();
    t_sched();
    t_frames();
    t_sni();
    give_verdict();
  end
endmodule
